// [design/phs_cfg.svh]
// Purpose: constants for the pci hold / stop / ready handshake block
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes:   encodings and counts only, no logic
`ifndef PHS_CFG_SVH
`define PHS_CFG_SVH
`define PHS_ASSERTED        1'b0
`define PHS_DEASSERTED      1'b1
`define PHS_OE_DRIVE        1'b0
`define PHS_OE_FLOAT        1'b1
`define PHS_RELEASE_CYCLES  2'h1
`define PHS_CNT_ZERO        2'h0
`endif

// [design/phs_pkg.sv]
// Purpose: types for the pci hold / stop / ready handshake block
// Assumes: nothing beyond the config header
// Notes:   one-hot state codes written out
package phs_pkg;
   typedef enum logic [4:0] {
      MST_IDLE    = 5'b0_0001,
      MST_REQ     = 5'b0_0010,
      MST_OWN     = 5'b0_0100,
      MST_RELEASE = 5'b0_1000,
      MST_WAIT    = 5'b1_0000
   } phs_mst_t;
   typedef enum logic [2:0] {
      TGT_IDLE = 3'b001,
      TGT_DATA = 3'b010,
      TGT_TURN = 3'b100
   } phs_tgt_t;
endpackage

// [design/phs_edge_event.sv]
// Purpose: register an active-low line and flag each new active sample once
// Assumes: line is synchronous to clk
// Notes:   pulse lasts one clock, gated by an enable
`timescale 1ns/1ps
`include "phs_cfg.svh"
module phs_edge_event (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // line and gating
   input  wire logic line_n,
   input  wire logic enable,
   // event out
   output logic      event_q
);
   logic line_q;
   logic prev_q;
   wire  fall_seen = (line_q == `PHS_ASSERTED) && (prev_q == `PHS_DEASSERTED);

   // sample the line and its previous value
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         line_q  <= `PHS_DEASSERTED;
         prev_q  <= `PHS_DEASSERTED;
         event_q <= 1'b0;
      end else begin
         line_q  <= line_n;
         prev_q  <= line_q;
         event_q <= fall_seen && enable;
      end
   end
endmodule // phs_edge_event

// [design/phs_handshake.sv]
// Purpose: pci hold request/grant, target stop/ready, initiator stop and error nmi
// Assumes: all pci inputs synchronous to clk; address/data and parity live elsewhere
// Notes:   shared pins are split into in / out / oe_n, oe_n low means driving
// Functional notes
// - low hold grant means we own the bus; high means no grant.
// - request bus by driving hold low; passive release is one clock high.
// - sampled system error with nmi enabled raises an nmi to the cpu.
// - as target, assert stop to ask the initiator to terminate.
// - as initiator, end the transaction when target stop is sampled.
// - stop driven only as target, otherwise treated as an input.
// - stop floats from reset until next driven as selected target.
// - data phase completes only when both ready lines sampled low.
// - target read: ready only while valid read data is driven.
// - target write: ready only when able to capture write data.
// - target ready driven as target, sampled as initiator.
// - target ready floats from reset until next driven as target.
// - error, stop and ready pins float unless driven in a transaction.
// - initiator ready only with valid write data or read capture ready.
`timescale 1ns/1ps
`include "phs_cfg.svh"
module phs_handshake (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic pci_bus_reset_n,
   // arbiter sideband
   output logic      bus_hold_request_n,
   input  wire logic bus_hold_grant_n,
   // initiator side user port
   input  wire logic mst_want,
   input  wire logic mst_release,
   input  wire logic mst_data_valid,
   output logic      mst_granted,
   output logic      mst_stopped,
   output logic      mst_phase_done,
   // initiator ready from the rest of the unit
   input  wire logic irdy_in_n,
   input  wire logic irdy_out_n,
   // target side user port
   input  wire logic tgt_select,
   input  wire logic tgt_is_read,
   input  wire logic tgt_data_ready,
   input  wire logic tgt_stop_req,
   input  wire logic tgt_last,
   output logic      tgt_phase_done,
   // stop pin
   input  wire logic stop_in_n,
   output logic      stop_out_n,
   output logic      stop_oe_n,
   // target ready pin
   input  wire logic trdy_in_n,
   output logic      trdy_out_n,
   output logic      trdy_oe_n,
   // system error pin
   input  wire logic serr_in_n,
   output logic      serr_out_n,
   output logic      serr_oe_n,
   // nmi
   input  wire logic nmi_enable,
   output logic      nmi_q
);
   phs_pkg::phs_mst_t mst_q, mst_d;
   phs_pkg::phs_tgt_t tgt_q, tgt_d;
   logic       hold_n_q;
   logic       granted_q;
   logic       stopped_q;
   logic       mst_done_q;
   logic       tgt_done_q;
   logic       stop_q;
   logic       stop_oe_q;
   logic       trdy_q;
   logic       trdy_oe_q;
   logic       nmi_hold_q;
   logic       serr_q;
   logic       serr_oe_q;
   logic [1:0] rel_cnt_q;
   logic       serr_event;

   // any reset, including pci reset for every clock it is held low, floats pins
   wire any_rst    = sys_rst || (pci_bus_reset_n == `PHS_ASSERTED);
   wire grant_seen = (bus_hold_grant_n == `PHS_ASSERTED);
   wire stop_seen  = (stop_in_n == `PHS_ASSERTED);
   wire irdy_seen  = (irdy_in_n == `PHS_ASSERTED);
   wire trdy_seen  = (trdy_in_n == `PHS_ASSERTED);
   wire own_irdy   = (irdy_out_n == `PHS_ASSERTED) && mst_data_valid;
   wire mst_active = (mst_q == phs_pkg::MST_OWN);
   wire tgt_active = (tgt_q == phs_pkg::TGT_DATA);
   // completion follows the ready pin the initiator sees, not the raw request
   wire tgt_ready  = tgt_active && (trdy_q == `PHS_ASSERTED);
   // stop leaves the data phase only once the pin has been shown low
   wire tgt_stop   = tgt_active && tgt_stop_req && (stop_q == `PHS_ASSERTED);
   // completion needs both ready lines low on the same edge
   wire mst_done   = mst_active && own_irdy && trdy_seen;
   wire tgt_done   = tgt_ready && irdy_seen;
   wire rel_done   = (rel_cnt_q == `PHS_RELEASE_CYCLES);
   wire tgt_rw_ok  = tgt_is_read || !tgt_is_read;

   // initiator ownership sequence
   always_comb begin
      mst_d = mst_q;
      case (mst_q)
         phs_pkg::MST_IDLE:    if (mst_want) mst_d = phs_pkg::MST_REQ;
         phs_pkg::MST_REQ:     if (grant_seen) mst_d = phs_pkg::MST_OWN;
         phs_pkg::MST_OWN: begin
            if (stop_seen) mst_d = phs_pkg::MST_WAIT;
            else if (mst_release) mst_d = phs_pkg::MST_RELEASE;
            else if (!grant_seen) mst_d = phs_pkg::MST_IDLE;
         end
         phs_pkg::MST_RELEASE: if (rel_done) mst_d = phs_pkg::MST_REQ;
         phs_pkg::MST_WAIT:    mst_d = mst_want ? phs_pkg::MST_REQ : phs_pkg::MST_IDLE;
         default:              mst_d = phs_pkg::MST_IDLE;
      endcase
   end

   // target data sequence, turnaround drives high one clock before floating
   always_comb begin
      tgt_d = tgt_q;
      case (tgt_q)
         phs_pkg::TGT_IDLE: if (tgt_select && tgt_rw_ok) tgt_d = phs_pkg::TGT_DATA;
         phs_pkg::TGT_DATA: if (tgt_stop || (tgt_done && tgt_last)) tgt_d = phs_pkg::TGT_TURN;
         phs_pkg::TGT_TURN: tgt_d = phs_pkg::TGT_IDLE;
         default:           tgt_d = phs_pkg::TGT_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge clk) begin
      if (any_rst) begin
         mst_q <= phs_pkg::MST_IDLE;
         tgt_q <= phs_pkg::TGT_IDLE;
      end else begin
         mst_q <= mst_d;
         tgt_q <= tgt_d;
      end
   end

   // hold request: low while requesting or owning, high for one release clock
   always_ff @(posedge clk) begin
      if (any_rst) begin
         hold_n_q  <= `PHS_DEASSERTED;
         rel_cnt_q <= `PHS_CNT_ZERO;
      end else begin
         hold_n_q  <= ((mst_d == phs_pkg::MST_REQ) || (mst_d == phs_pkg::MST_OWN))
                      ? `PHS_ASSERTED : `PHS_DEASSERTED;
         rel_cnt_q <= (mst_d == phs_pkg::MST_RELEASE) ? `PHS_RELEASE_CYCLES : `PHS_CNT_ZERO;
      end
   end

   // initiator status flags
   always_ff @(posedge clk) begin
      if (any_rst) begin
         granted_q  <= 1'b0;
         stopped_q  <= 1'b0;
         mst_done_q <= 1'b0;
      end else begin
         granted_q  <= (mst_d == phs_pkg::MST_OWN);
         stopped_q  <= mst_active && stop_seen;
         mst_done_q <= mst_done;
      end
   end

   // stop pin, output only as target, input otherwise
   always_ff @(posedge clk) begin
      if (any_rst) begin
         stop_q    <= `PHS_DEASSERTED;
         stop_oe_q <= `PHS_OE_FLOAT;
      end else begin
         stop_q    <= (tgt_d == phs_pkg::TGT_DATA) && tgt_stop_req ? `PHS_ASSERTED : `PHS_DEASSERTED;
         stop_oe_q <= (tgt_d == phs_pkg::TGT_IDLE) ? `PHS_OE_FLOAT : `PHS_OE_DRIVE;
      end
   end

   // target ready pin, output only as target, input as initiator
   always_ff @(posedge clk) begin
      if (any_rst) begin
         trdy_q     <= `PHS_DEASSERTED;
         trdy_oe_q  <= `PHS_OE_FLOAT;
         tgt_done_q <= 1'b0;
      end else begin
         trdy_q     <= (tgt_d == phs_pkg::TGT_DATA) && tgt_data_ready
                       ? `PHS_ASSERTED : `PHS_DEASSERTED;
         trdy_oe_q  <= (tgt_d == phs_pkg::TGT_IDLE) ? `PHS_OE_FLOAT : `PHS_OE_DRIVE;
         tgt_done_q <= tgt_done;
      end
   end

   // one nmi pulse per system error pulse when enabled
   phs_edge_event u_serr_event (
      .clk     (clk),
      .sys_rst (any_rst),
      .line_n  (serr_in_n),
      .enable  (nmi_enable),
      .event_q (serr_event)
   );

   always_ff @(posedge clk) begin
      if (any_rst) nmi_hold_q <= 1'b0;
      else         nmi_hold_q <= serr_event;
   end

   // error pin held released; no error source lives in this block
   always_ff @(posedge clk) begin
      if (any_rst) begin
         serr_q    <= `PHS_DEASSERTED;
         serr_oe_q <= `PHS_OE_FLOAT;
      end else begin
         serr_q    <= `PHS_DEASSERTED;
         serr_oe_q <= `PHS_OE_FLOAT;
      end
   end

   // outputs straight from flip-flops; error pin never driven here
   assign bus_hold_request_n = hold_n_q;
   assign mst_granted        = granted_q;
   assign mst_stopped        = stopped_q;
   assign mst_phase_done     = mst_done_q;
   assign tgt_phase_done     = tgt_done_q;
   assign stop_out_n         = stop_q;
   assign stop_oe_n          = stop_oe_q;
   assign trdy_out_n         = trdy_q;
   assign trdy_oe_n          = trdy_oe_q;
   assign serr_out_n         = serr_q;
   assign serr_oe_n          = serr_oe_q;
   assign nmi_q              = nmi_hold_q;
endmodule // phs_handshake

// [tb/phs_handshake_assertions.sv]
// Purpose: port checks
// Assumes: one clock
// Notes:   bound below
`timescale 1ns/1ps
module phs_handshake_assertions (
   // clock, resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pci_bus_reset_n,
   // initiator
   input wire logic bus_hold_request_n,
   input wire logic bus_hold_grant_n,
   input wire logic mst_release,
   input wire logic mst_data_valid,
   input wire logic mst_granted,
   input wire logic mst_stopped,
   input wire logic mst_phase_done,
   input wire logic irdy_in_n,
   input wire logic irdy_out_n,
   // target, error
   input wire logic tgt_data_ready,
   input wire logic tgt_stop_req,
   input wire logic tgt_phase_done,
   input wire logic stop_in_n,
   input wire logic stop_out_n,
   input wire logic stop_oe_n,
   input wire logic trdy_in_n,
   input wire logic trdy_out_n,
   input wire logic trdy_oe_n,
   input wire logic serr_in_n,
   input wire logic serr_oe_n,
   input wire logic nmi_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst || !pci_bus_reset_n);
   chk_grant_seen: assert property (mst_granted |->
      $past(!bus_hold_grant_n) || $past(!bus_hold_grant_n, 2)) else $error("granted without grant");
   chk_release_one: assert property (mst_release && mst_granted |=>
      ##[0:1] $rose(bus_hold_request_n) ##1 !bus_hold_request_n) else $error("release length");
   chk_nmi_source: assert property (nmi_q |-> $past(!serr_in_n, 3)) else $error("nmi cause");
   chk_nmi_once: assert property (nmi_q |=> !nmi_q) else $error("nmi twice");
   chk_stop_cause: assert property (!stop_oe_n && !stop_out_n |->
      $past(tgt_stop_req) || $past(tgt_stop_req, 2)) else $error("stop cause");
   chk_trdy_ready: assert property (!trdy_oe_n && !trdy_out_n |-> $past(tgt_data_ready))
      else $error("trdy cause");
   chk_tgt_done: assert property (tgt_phase_done |-> $past(!trdy_out_n && !irdy_in_n))
      else $error("target done cause");
   chk_mst_done: assert property (mst_phase_done |->
      $past(!irdy_out_n && mst_data_valid && !trdy_in_n)) else $error("master done cause");
   chk_stop_sampled: assert property (mst_stopped |-> $past(!stop_in_n)) else $error("stop cause");
   chk_reset_float: assert property ($past(!pci_bus_reset_n) |-> stop_oe_n && trdy_oe_n)
      else $error("pins not floated");
   chk_serr_float: assert property (serr_oe_n) else $error("serr driven");
   cover property (nmi_q);
   cover property (tgt_phase_done);
   cover property (mst_stopped);
   cover property (mst_release && mst_granted);
endmodule // phs_handshake_assertions
bind phs_handshake phs_handshake_assertions u_chk (.*);

// [tb/phs_arb_model.sv]
// Purpose: arbiter model
// Assumes: lag set by bench
// Notes:   grant held until request drops
`timescale 1ns/1ps
module phs_arb_model (
   // clock, reset
   input  wire logic       clk,
   input  wire logic       rst,
   // sideband
   input  wire logic       req_n,
   input  wire logic [1:0] lag,
   output logic            grant_n
);
   logic [1:0] cnt_q;
   // grant after lag, drop only once request gone
   always_ff @(posedge clk) begin
      if (rst || req_n) begin
         grant_n <= 1'b1;
         cnt_q   <= 2'h0;
      end else if (cnt_q == lag) grant_n <= 1'b0;
      else cnt_q <= cnt_q + 2'h1;
   end
endmodule // phs_arb_model

// [tb/pci_hold_stop_ready_handshake_bench.sv]
// Purpose: bench
// Assumes: arbiter model
// Notes:   queue of expected pulses
`timescale 1ns/1ps
`define CHK(g,e) begin cmp_count++; if ((g)!==(e)) begin miscompares++; $display("[FAIL] %0t mismatch", $time); end end
module pci_hold_stop_ready_handshake_bench;
   logic clk=0, sys_rst=1, pci_bus_reset_n=1, bus_hold_request_n, bus_hold_grant_n;
   logic mst_want=0, mst_release=0, mst_data_valid=0, mst_granted, mst_stopped, mst_phase_done;
   logic irdy_in_n=1, irdy_out_n=1, tgt_select=0, tgt_is_read=0, tgt_data_ready=0;
   logic tgt_stop_req=0, tgt_last=0, tgt_phase_done, stop_in_n=1, stop_out_n, stop_oe_n;
   logic trdy_in_n=1, trdy_out_n, trdy_oe_n, serr_in_n=1, serr_out_n, serr_oe_n, nmi_enable=0, nmi_q;
   logic [1:0] lag=0;
   logic [1:0] q[$];
   logic [31:0] seed=32'h1e2f_2756;
   int miscompares=0, cmp_count=0;
   always #5 clk = ~clk;
   phs_handshake u_dut (.*);
   phs_arb_model u_arb (.clk, .rst(sys_rst), .req_n(bus_hold_request_n), .lag, .grant_n(bus_hold_grant_n));
   function logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   task cyc(int n); repeat (n) @(posedge clk); #1; endtask
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task wait_grant; int i;
      for (i = 0; i < 50 && mst_granted !== 1'b1; i++) cyc(1);
      if (i == 50) begin miscompares++; finish_test(); end
   endtask
   // each output pulse takes the oldest note
   always @(negedge clk) if ((nmi_q | tgt_phase_done | mst_stopped | mst_phase_done) === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) `CHK({mst_stopped | mst_phase_done, tgt_phase_done | mst_phase_done}, q.pop_front())
   end
   initial begin #100us; miscompares++; finish_test(); end
   initial begin
      cyc(10); sys_rst = 0;
      // hold, data phase, release, stop
      lag = 2'(rnd()); mst_want = 1; cyc(2);
      `CHK(bus_hold_request_n, 1'b0)
      wait_grant();
      `CHK(bus_hold_grant_n, 1'b0)
      irdy_out_n = 0; mst_data_valid = 1; cyc(1);
      trdy_in_n = 0; q.push_back(2'h3); cyc(1);
      irdy_out_n = 1; trdy_in_n = 1; mst_data_valid = 0; mst_release = 1; cyc(1);
      mst_release = 0; cyc(6); wait_grant();
      stop_in_n = 0; q.push_back(2'h2); cyc(1);
      stop_in_n = 1; mst_want = 0; cyc(6); $display("master test done");
      // target stop, then target transfer
      tgt_is_read = 1'(rnd()); tgt_select = 1; irdy_in_n = 0; cyc(2);
      `CHK(trdy_oe_n, 1'b0)
      `CHK(trdy_out_n, 1'b1)
      tgt_stop_req = 1; cyc(1);
      `CHK(stop_out_n, 1'b0)
      cyc(1);
      `CHK(stop_out_n, 1'b1)
      `CHK(stop_oe_n, 1'b0)
      tgt_select = 0; tgt_stop_req = 0; cyc(4);
      `CHK(stop_oe_n, 1'b1)
      tgt_select = 1; tgt_data_ready = 1; tgt_last = 1; q.push_back(2'h1); cyc(1);
      tgt_select = 0; tgt_data_ready = 0; cyc(6); irdy_in_n = 1; $display("target test done");
      // error pulses, enabled then masked
      for (int e = 1; e >= 0; e--) begin
         nmi_enable = 1'(e); cyc(1); serr_in_n = 0;
         if (e) q.push_back(2'h0);
         cyc(1 + rnd() % 4); serr_in_n = 1; cyc(8);
      end
      $display("error test done");
      // pci reset while selected
      tgt_select = 1; cyc(2); pci_bus_reset_n = 0; cyc(1); pci_bus_reset_n = 1; tgt_select = 0;
      `CHK(trdy_oe_n, 1'b1)
      `CHK(stop_oe_n, 1'b1)
      `CHK(serr_oe_n, 1'b1)
      `CHK(serr_out_n, 1'b1)
      cyc(5);
      `CHK(q.size(), 0)
      $display("reset test done");
      finish_test();
   end
endmodule // pci_hold_stop_ready_handshake_bench
